// ===== tb/bcs_mem_model.sv
`timescale 1ns/1ps
module bcs_mem_model (
  input wire logic              clk,
  input wire bcs_pkg::bcs_bus_t bus,
  input wire logic [7:0]        vector,
  output logic [7:0]            data_in
);
  import bcs_pkg::*;
  logic [7:0] last_r = 8'h00;
  // A released bus toggles every cycle, so a stale byte never passes for a read.
  always_comb begin
    if (!bus.fetch_status && bus.read_n) begin
      data_in = vector;
    end else if (!bus.read_n) begin
      data_in = bus.address[7:0] ^ bus.address[15:8] ^ 8'h3c;
    end else begin
      data_in = ~last_r;
    end
  end
  always_ff @(posedge clk) begin
    last_r <= data_in;
  end
endmodule

// ===== tb/bcs_sequencer_chk.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"
module bcs_sequencer_chk (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              start,
  input wire bcs_pkg::bcs_op_t  op,
  input wire logic [15:0]       program_counter,
  input wire logic [15:0]       stack_pointer,
  input wire logic [15:0]       indirect_pointer_pair,
  input wire logic [15:0]       index_address,
  input wire logic [7:0]        counter_reg,
  input wire logic [7:0]        vector_base,
  input wire logic              wake,
  input wire logic [7:0]        data_in,
  input wire logic              busy,
  input wire logic              done,
  input wire bcs_pkg::bcs_bus_t bus,
  input wire logic [15:0]       new_program_counter,
  input wire logic              new_pc_valid
);
  import bcs_pkg::*;
  logic [6:0] s;
  assign s = {bus.read_n, bus.write_n, bus.memory_request_n, bus.io_request_n,
              bus.first_fetch_n, bus.halt_status_n, bus.fetch_status};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence fetch_seq;
    (s == 7'h2a) [*3] ##1 (s != 7'h2a);
  endsequence
  sequence ack_seq;
    (s == 7'h72) [*5] ##1 (s != 7'h72);
  endsequence
  a_fetch_three: assert property ($rose(s == 7'h2a) |-> fetch_seq)
    else $error("first fetch not three states");
  a_ack_five: assert property ($rose(s == 7'h72) |-> ack_seq)
    else $error("acknowledge not five states");
  a_intx_entry: assert property ($rose(s == 7'h7e) |->
    (s == 7'h7e) [*5] ##1 (s == 7'h7f) ##1 !bus.write_n) else $error("interrupt entry wrong");
  a_mode1_push: assert property (((op == BCS_OP_IM1) && (s == 7'h72)) ##1 (s != 7'h72)
    |-> !bus.write_n) else $error("mode 1 push late");
  a_push_order: assert property ($fell(bus.write_n) &&
    bus.address[15:0] == stack_pointer - 16'h1 |-> ##3 !bus.write_n &&
    bus.address[15:0] == stack_pointer - 16'h2) else $error("push order wrong");
  a_sleep_bus: assert property (!bus.halt_status_n |->
    bus.address == `BCS_SLEEP_ADDR && bus.data_oe_n && s[6:2] == 5'h1f)
    else $error("sleep bus wrong");
  a_io_addr: assert property (s == 7'h37 |->
    bus.address[15:0] == {`BCS_IO_HIGH, counter_reg}) else $error("io address wrong");
  a_idle_float: assert property (s == 7'h7f |-> bus.data_oe_n)
    else $error("data driven in idle");
  a_write_drive: assert property (!bus.write_n |-> !bus.data_oe_n)
    else $error("write cycle not driving data");
endmodule
bind bcs_sequencer bcs_sequencer_chk chk_u (.clk(clk), .sys_rst(sys_rst), .start(start),
  .op(op), .program_counter(program_counter), .stack_pointer(stack_pointer),
  .indirect_pointer_pair(indirect_pointer_pair), .index_address(index_address),
  .counter_reg(counter_reg), .vector_base(vector_base), .wake(wake), .data_in(data_in),
  .busy(busy), .done(done), .bus(bus), .new_program_counter(new_program_counter),
  .new_pc_valid(new_pc_valid));

// ===== tb/bcs_sequencer_tb.sv
`timescale 1ns/1ps
module bcs_sequencer_tb;
  import bcs_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        start = 1'b0;
  logic        wake = 1'b0;
  bcs_op_t     op = BCS_OP_SCF;
  logic [15:0] pc = 16'h0;
  logic [15:0] sp = 16'h0;
  logic [15:0] hl = 16'h0;
  logic [15:0] ix = 16'h0;
  logic [7:0]  cr = 8'h0;
  logic [7:0]  vb = 8'h0;
  logic [7:0]  vec = 8'h0;
  logic [7:0]  din;
  logic        busy;
  logic        done;
  bcs_bus_t    bus;
  logic [15:0] npc;
  logic        npc_v;
  logic [6:0]  st;
  logic [26:0] prev = 27'h0;
  logic [35:0] e;
  logic [35:0] q_bus[$];
  logic [15:0] q_pc[$];
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          seed = 32'h07cd5571;
  always #2.5 clk = ~clk;
  assign st = {bus.read_n, bus.write_n, bus.memory_request_n, bus.io_request_n,
               bus.first_fetch_n, bus.halt_status_n, bus.fetch_status};
  bcs_sequencer dut_u (.clk(clk), .sys_rst(sys_rst), .start(start), .op(op),
    .program_counter(pc), .stack_pointer(sp), .indirect_pointer_pair(hl), .index_address(ix),
    .counter_reg(cr), .vector_base(vb), .wake(wake), .data_in(din), .busy(busy), .done(done),
    .bus(bus), .new_program_counter(npc), .new_pc_valid(npc_v));
  bcs_mem_model mem_u (.clk(clk), .bus(bus), .vector(vec), .data_in(din));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_bus(input logic [35:0] g, input logic [35:0] x);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t: bus got %h expected %h", $time, g, x);
    end
  endtask
  task automatic cmp_pc(input logic [15:0] g, input logic [15:0] x);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t: value got %h expected %h", $time, g, x);
    end
  endtask
  task automatic add(input logic [6:0] s, input logic [15:0] a, input logic [8:0] d = 9'h0);
    q_bus.push_back({d[8], s, 4'h0, a, d[7:0]});
  endtask
  task automatic push(input logic [15:0] s, input logic [15:0] v);
    add(7'h4f, s - 16'h1, {1'b1, v[15:8]});
    add(7'h4f, s - 16'h2, {1'b1, v[7:0]});
  endtask
  task automatic fetch2(input logic [15:0] p);
    add(7'h2a, p);
    add(7'h2b, p + 16'h1);
  endtask
  task automatic tbl(input logic [7:0] b, input logic [7:0] v);
    add(7'h2f, {b, v});
    add(7'h2f, {b, v + 8'h1});
    q_pc.push_back({b ^ (v + 8'h1) ^ 8'h3c, b ^ v ^ 8'h3c});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_op(input bcs_op_t o);
    logic [15:0] p, s, h, x;
    logic [31:0] r;
    int          i;
    int          k;
    {s, p} = $random(seed);
    {h, x} = $random(seed);
    r = $random(seed);
    k = 0;
    case (o)
      BCS_OP_SCF: add(7'h2a, p);
      BCS_OP_RST, BCS_OP_NMI: begin
        add(7'h2a, p);
        push(s, p);
      end
      BCS_OP_BIT_REG, BCS_OP_TST_G: fetch2(p);
      BCS_OP_BIT_HL: begin
        fetch2(p);
        add(7'h2f, h);
        add(7'h4f, h);
      end
      BCS_OP_BIT_IX: begin
        fetch2(p);
        add(7'h2f, p + 16'h2);
        add(7'h2b, p + 16'h3);
        add(7'h2f, x);
        add(7'h4f, x);
      end
      BCS_OP_SLP: begin
        fetch2(p);
        q_bus.push_back({1'b0, 7'h7d, 20'hfffff, 8'h00});
      end
      BCS_OP_IO_TEST_INSTRUCTION: begin
        fetch2(p);
        add(7'h2f, p + 16'h2);
        add(7'h37, {8'h00, r[7:0]});
      end
      BCS_OP_TST_M, BCS_OP_TST_HL: begin
        fetch2(p);
        add(7'h2f, (o == BCS_OP_TST_M) ? p + 16'h2 : h);
      end
      BCS_OP_IM0_CALL: begin
        add(7'h72, p);
        add(7'h2f, p);
        add(7'h2f, p + 16'h1);
        push(s, p + 16'h2);
      end
      default: begin
        add((o == BCS_OP_INTX) ? 7'h7e : 7'h72, p);
        push(s, p);
        if (o == BCS_OP_IM2 || o == BCS_OP_INTX) tbl(r[15:8], {r[23:17], 1'b0});
      end
    endcase
    @(posedge clk);
    wake <= 1'b0;
    pc <= p;
    sp <= s;
    hl <= h;
    ix <= x;
    cr <= r[7:0];
    vb <= r[15:8];
    vec <= {r[23:17], 1'b0};
    op <= o;
    start <= 1'b1;
    @(posedge clk);
    // A start held into the busy phase with another op must change nothing.
    if (o == BCS_OP_IM2) begin
      op <= BCS_OP_SCF;
      @(posedge clk);
    end
    start <= 1'b0;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (done === 1'b1) break;
      if (bus.halt_status_n === 1'b0) k++;
      @(posedge clk);
      wake <= (k > 3);
    end
    repeat (2) @(posedge clk);
    cmp_pc(16'(q_bus.size() + q_pc.size() + (i == 300)), 16'h0);
    $display("test op %0d finished", o);
  endtask
  always @(posedge clk) begin
    if (!sys_rst && st != 7'h7f && {st, bus.address} != prev) begin
      e = (q_bus.size() > 0) ? q_bus.pop_front() : 36'h0;
      cmp_bus({e[35], st, bus.address, e[35] ? bus.data_out : 8'h00}, e);
    end
    if (!sys_rst && npc_v === 1'b1) begin
      cmp_pc(npc, (q_pc.size() > 0) ? q_pc.pop_front() : 16'h0);
    end
    prev = {st, bus.address};
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    cmp_bus({busy, st, bus.address, 8'h00}, {1'b0, 7'h7f, 20'h00000, 8'h00});
    for (int j = 0; j < 48; j++) run_op(bcs_op_t'(j % 16));
    report_and_stop();
  end
endmodule

// ===== verilog/bcs_consts.svh
// Operation
// RQ1: Set-carry is one three-state opcode fetch with fetch strobes low.
// RQ2: Restart fetches, idles two states, pushes counter high then low.
// RQ3: Register bit set/reset: two fetches, then one idle state.
// RQ4: Bit set/reset on pointer operand: fetch two, read, idle, write back.
// RQ5: Indexed bit ops: two fetches, displacement, third opcode, read, idle, write.
// RQ6: Sleep drives all-ones address, floats data, halt status low.
// RQ7: I/O test: two fetches, immediate, then I/O read at counter with zero high.
// RQ8: Register test: two fetches then one idle state with data floating.
// RQ9: Immediate test: two fetches then memory read of the immediate operand.
// RQ10: Memory test: two fetches, one idle, then read at pointer pair.
// RQ11: Non-maskable entry: fetch cycle, two idles, push counter high then low.
// RQ12: Mode 0 acknowledge: five states, two waits, I/O request and fetch low.
// RQ13: Mode 0 call: read two address bytes, idle, push counter plus two.
// RQ14: Mode 1: acknowledge then push high and low with no idle.
// RQ15: Mode 2: vector captured, idle, push, read table at base and vector.
// RQ16: Other interrupts: five-state cycle, strobes high, idle, push, read table.
// RQ17: New counter low byte from first table read, high from second.
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH
`define BCS_ADDR_W      20
`define BCS_SLEEP_ADDR  20'hfffff
`define BCS_IO_HIGH     8'h00
`define BCS_T3_STATES   3'h3
`define BCS_T5_STATES   3'h5
`define BCS_WAIT_FIRST  3'h2
`define BCS_WAIT_LAST   3'h3
`endif

// ===== verilog/bcs_pkg.sv
package bcs_pkg;
  typedef enum logic [4:0] {
    BCS_OP_SCF    = 5'h00, BCS_OP_RST   = 5'h01, BCS_OP_BIT_REG = 5'h02,
    BCS_OP_BIT_HL = 5'h03, BCS_OP_BIT_IX = 5'h04, BCS_OP_SLP    = 5'h05,
    BCS_OP_IO_TEST_INSTRUCTION  = 5'h06, BCS_OP_TST_G = 5'h07, BCS_OP_TST_M  = 5'h08,
    BCS_OP_TST_HL = 5'h09, BCS_OP_NMI   = 5'h0a, BCS_OP_IM0_RST = 5'h0b,
    BCS_OP_IM0_CALL = 5'h0c, BCS_OP_IM1 = 5'h0d, BCS_OP_IM2    = 5'h0e,
    BCS_OP_INTX   = 5'h0f
  } bcs_op_t;
  typedef enum logic [3:0] {
    BCS_MC_IDLE = 4'h0, BCS_MC_FETCH1 = 4'h1, BCS_MC_FETCH2 = 4'h2, BCS_MC_INT = 4'h3,
    BCS_MC_MEMRD = 4'h4, BCS_MC_MEMWR = 4'h5, BCS_MC_IORD = 4'h6, BCS_MC_ACK = 4'h7,
    BCS_MC_ACKX = 4'h8, BCS_MC_SLEEP = 4'h9, BCS_MC_FETCH3 = 4'ha
  } bcs_mc_t;
  typedef enum logic [2:0] {
    BCS_A_PC = 3'h0, BCS_A_SP = 3'h1, BCS_A_PTR = 3'h2, BCS_A_IO = 3'h3,
    BCS_A_VEC = 3'h4, BCS_A_ONES = 3'h5
  } bcs_asrc_t;
  typedef struct packed {
    bcs_mc_t   kind;
    bcs_asrc_t asrc;
    logic [1:0] offs;
  } bcs_step_t;
  typedef struct packed {
    logic [19:0] address;
    logic [7:0]  data_out;
    logic        data_oe_n;
    logic        read_n;
    logic        write_n;
    logic        memory_request_n;
    logic        io_request_n;
    logic        first_fetch_n;
    logic        halt_status_n;
    logic        fetch_status;
  } bcs_bus_t;
endpackage

// ===== verilog/bcs_sequencer.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"
module bcs_sequencer (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire bcs_pkg::bcs_op_t op,
  input  wire logic [15:0]      program_counter,
  input  wire logic [15:0]      stack_pointer,
  input  wire logic [15:0]      indirect_pointer_pair,
  input  wire logic [15:0]      index_address,
  input  wire logic [7:0]       counter_reg,
  input  wire logic [7:0]       vector_base,
  input  wire logic             wake,
  input  wire logic [7:0]       data_in,
  output logic                  busy,
  output logic                  done,
  output bcs_pkg::bcs_bus_t     bus,
  output logic [15:0]           new_program_counter,
  output logic                  new_pc_valid
);
  import bcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        active;
    bcs_op_t     op;
    logic [3:0]  step;
    logic [2:0]  tstate;
    logic [15:0] pc;
    logic [7:0]  vector;
    logic [7:0]  tbl_low;
    logic [15:0] npc;
    logic        npc_valid;
    logic        done;
    logic        sleeping;
    bcs_bus_t    bus;
  } bcs_state_t;

  bcs_state_t state_r;
  bcs_state_t state_nxt;
  bcs_step_t  cur;
  logic       last;
  logic [6:0] strobes;
  logic [2:0] len;

  ////////////////////////////////////////////////////////////////////////////
  // Step table: each operation is a short list of machine cycles. Idle cycles
  // are one state long, bus cycles three, acknowledge cycles five.
  function automatic bcs_step_t mk(bcs_mc_t k, bcs_asrc_t a, logic [1:0] o);
    bcs_step_t s;
    s.kind = k;
    s.asrc = a;
    s.offs = o;
    return s;
  endfunction

  always_comb begin
    cur  = mk(BCS_MC_IDLE, BCS_A_PC, 2'h0);
    last = 1'b0;
    case (state_r.op)
      BCS_OP_SCF: begin
        cur  = mk(BCS_MC_FETCH1, BCS_A_PC, 2'h0); // RQ1
        last = 1'b1;
      end
      BCS_OP_RST, BCS_OP_NMI: begin
        case (state_r.step)
          4'h0: cur = mk(BCS_MC_FETCH1, BCS_A_PC, 2'h0); // RQ11
          4'h1, 4'h2: cur = mk(BCS_MC_INT, BCS_A_PC, 2'h0); // RQ2
          4'h3: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h1); // RQ2
          default: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h2); // RQ11
        endcase
        last = (state_r.step == 4'h4);
      end
      BCS_OP_IM0_RST: begin
        case (state_r.step)
          4'h0: cur = mk(BCS_MC_ACK, BCS_A_PC, 2'h0); // RQ12
          4'h1, 4'h2: cur = mk(BCS_MC_INT, BCS_A_PC, 2'h0);
          4'h3: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h1);
          default: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h2);
        endcase
        last = (state_r.step == 4'h4);
      end
      BCS_OP_IM0_CALL: begin
        case (state_r.step)
          4'h0: cur = mk(BCS_MC_ACK, BCS_A_PC, 2'h0);
          4'h1: cur = mk(BCS_MC_MEMRD, BCS_A_PC, 2'h0); // RQ13
          4'h2: cur = mk(BCS_MC_MEMRD, BCS_A_PC, 2'h1); // RQ13
          4'h3: cur = mk(BCS_MC_INT, BCS_A_PC, 2'h0);
          4'h4: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h1);
          default: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h2);
        endcase
        last = (state_r.step == 4'h5);
      end
      BCS_OP_IM1: begin
        case (state_r.step)
          4'h0: cur = mk(BCS_MC_ACK, BCS_A_PC, 2'h0);
          4'h1: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h1); // RQ14
          default: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h2); // RQ14
        endcase
        last = (state_r.step == 4'h2);
      end
      BCS_OP_IM2, BCS_OP_INTX: begin
        case (state_r.step)
          4'h0: cur = (state_r.op == BCS_OP_IM2) ? mk(BCS_MC_ACK, BCS_A_PC, 2'h0)
                                                 : mk(BCS_MC_ACKX, BCS_A_PC, 2'h0); // RQ16
          4'h1: cur = mk(BCS_MC_INT, BCS_A_PC, 2'h0); // RQ15
          4'h2: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h1);
          4'h3: cur = mk(BCS_MC_MEMWR, BCS_A_SP, 2'h2);
          4'h4: cur = mk(BCS_MC_MEMRD, BCS_A_VEC, 2'h0); // RQ15
          default: cur = mk(BCS_MC_MEMRD, BCS_A_VEC, 2'h1); // RQ15
        endcase
        last = (state_r.step == 4'h5);
      end
      default: begin
        // Every remaining operation opens with two opcode fetches.
        case (state_r.step)
          4'h0: cur = mk(BCS_MC_FETCH1, BCS_A_PC, 2'h0);
          4'h1: cur = mk(BCS_MC_FETCH2, BCS_A_PC, 2'h1);
          default: cur = mk(BCS_MC_IDLE, BCS_A_PC, 2'h0);
        endcase
        case (state_r.op)
          BCS_OP_BIT_REG, BCS_OP_TST_G: begin
            if (state_r.step == 4'h2) cur = mk(BCS_MC_INT, BCS_A_PC, 2'h0); // RQ8
            last = (state_r.step == 4'h2);
          end
          BCS_OP_BIT_HL: begin
            if (state_r.step == 4'h2) cur = mk(BCS_MC_MEMRD, BCS_A_PTR, 2'h0); // RQ4
            if (state_r.step == 4'h3) cur = mk(BCS_MC_INT, BCS_A_PC, 2'h0);
            if (state_r.step == 4'h4) cur = mk(BCS_MC_MEMWR, BCS_A_PTR, 2'h0); // RQ4
            last = (state_r.step == 4'h4);
          end
          BCS_OP_BIT_IX: begin
            if (state_r.step == 4'h2) cur = mk(BCS_MC_MEMRD, BCS_A_PC, 2'h2); // RQ5
            if (state_r.step == 4'h3) cur = mk(BCS_MC_FETCH3, BCS_A_PC, 2'h3); // RQ5
            if (state_r.step == 4'h4) cur = mk(BCS_MC_MEMRD, BCS_A_IO, 2'h1);
            if (state_r.step == 4'h5) cur = mk(BCS_MC_INT, BCS_A_PC, 2'h0);
            if (state_r.step == 4'h6) cur = mk(BCS_MC_MEMWR, BCS_A_IO, 2'h1); // RQ5
            last = (state_r.step == 4'h6);
          end
          BCS_OP_SLP: begin
            if (state_r.step == 4'h2) cur = mk(BCS_MC_SLEEP, BCS_A_ONES, 2'h0); // RQ6
            last = (state_r.step == 4'h2) && wake;
          end
          BCS_OP_IO_TEST_INSTRUCTION: begin
            if (state_r.step == 4'h2) cur = mk(BCS_MC_MEMRD, BCS_A_PC, 2'h2);
            if (state_r.step == 4'h3) cur = mk(BCS_MC_IORD, BCS_A_IO, 2'h0); // RQ7
            last = (state_r.step == 4'h3);
          end
          BCS_OP_TST_M: begin
            if (state_r.step == 4'h2) cur = mk(BCS_MC_MEMRD, BCS_A_PC, 2'h2); // RQ9
            last = (state_r.step == 4'h2);
          end
          BCS_OP_TST_HL: begin
            if (state_r.step == 4'h2) cur = mk(BCS_MC_INT, BCS_A_PC, 2'h0); // RQ10
            if (state_r.step == 4'h3) cur = mk(BCS_MC_MEMRD, BCS_A_PTR, 2'h0); // RQ10
            last = (state_r.step == 4'h3);
          end
          default: last = 1'b1;
        endcase
      end
    endcase
  end

  bcs_strobe u_strobe (
    .in_cycle (state_r.active),
    .kind     (cur.kind),
    .strobes  (strobes)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt           = state_r;
    state_nxt.done      = 1'b0;
    state_nxt.npc_valid = 1'b0;
    case (cur.kind)
      BCS_MC_ACK, BCS_MC_ACKX: len = `BCS_T5_STATES; // RQ12
      BCS_MC_INT, BCS_MC_SLEEP: len = 3'h1;
      default: len = `BCS_T3_STATES;
    endcase
    if (!state_r.active) begin
      state_nxt.bus = '1;
      state_nxt.bus.data_out = 8'h00;
      if (start) begin
        state_nxt.active = 1'b1;
        state_nxt.op     = op;
        state_nxt.step   = 4'h0;
        state_nxt.tstate = 3'h0;
        state_nxt.pc     = program_counter;
      end
    end else begin
      {state_nxt.bus.read_n, state_nxt.bus.write_n, state_nxt.bus.memory_request_n,
       state_nxt.bus.io_request_n, state_nxt.bus.first_fetch_n,
       state_nxt.bus.halt_status_n, state_nxt.bus.fetch_status} = strobes;
      // Data floats in every cycle but a write; sleep floats too.
      state_nxt.bus.data_oe_n = (cur.kind != BCS_MC_MEMWR); // RQ6
      case (cur.asrc)
        BCS_A_PC:  state_nxt.bus.address = {4'h0, state_r.pc + {14'h0, cur.offs}};
        BCS_A_SP:  state_nxt.bus.address = {4'h0, stack_pointer - {14'h0, cur.offs}};
        BCS_A_PTR: state_nxt.bus.address = {4'h0, indirect_pointer_pair};
        BCS_A_IO:  state_nxt.bus.address = cur.kind == BCS_MC_IORD
                     ? {4'h0, `BCS_IO_HIGH, counter_reg} // RQ7
                     : {4'h0, index_address};
        BCS_A_VEC: state_nxt.bus.address =
                     {4'h0, vector_base, state_r.vector + {7'h0, cur.offs[0]}};
        default:   state_nxt.bus.address = `BCS_SLEEP_ADDR; // RQ6
      endcase
      // The call target pushes the counter plus two, high byte first.
      if (cur.kind == BCS_MC_MEMWR && cur.asrc == BCS_A_SP) begin
        if (state_r.op == BCS_OP_IM0_CALL)
          state_nxt.bus.data_out = cur.offs[0] ? 8'(({16'h0} + state_r.pc + 16'h2) >> 8)
                                               : 8'(state_r.pc + 16'h2); // RQ13
        else
          state_nxt.bus.data_out = cur.offs[0] ? state_r.pc[15:8] : state_r.pc[7:0]; // RQ2
      end
      // Wait states hold the acknowledge open at T2 so the peripheral can drive.
      state_nxt.tstate = state_r.tstate + 3'h1;
      if (state_r.tstate + 3'h1 == len) begin
        // The other interrupt sources hand their vector over in the first cycle too.
        if ((cur.kind == BCS_MC_ACK && state_r.op == BCS_OP_IM2) || cur.kind == BCS_MC_ACKX)
          state_nxt.vector = data_in; // RQ15 RQ16
        if (cur.kind == BCS_MC_MEMRD && cur.asrc == BCS_A_VEC) begin
          if (!cur.offs[0]) state_nxt.tbl_low = data_in; // RQ17
          else begin
            state_nxt.npc       = {data_in, state_r.tbl_low}; // RQ17
            state_nxt.npc_valid = 1'b1;
          end
        end
        state_nxt.tstate = 3'h0;
        if (last) begin
          state_nxt.active = 1'b0;
          state_nxt.done   = 1'b1;
        end else if (!(cur.kind == BCS_MC_SLEEP)) begin
          state_nxt.step = state_r.step + 4'h1;
        end else begin
          state_nxt.tstate = 3'h0;
        end
      end
      state_nxt.sleeping = (cur.kind == BCS_MC_SLEEP);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
      state_r.bus <= '1;
      state_r.bus.data_out <= 8'h00;
      state_r.bus.address <= 20'h00000;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign busy                = state_r.active;
  assign done                = state_r.done;
  assign bus                 = state_r.bus;
  assign new_program_counter = state_r.npc;
  assign new_pc_valid        = state_r.npc_valid;
endmodule

// ===== verilog/bcs_strobe.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"
module bcs_strobe (
  input  wire logic             in_cycle,
  input  wire bcs_pkg::bcs_mc_t kind,
  output logic [6:0]            strobes
);
  import bcs_pkg::*;
  // Strobe order: read, write, memory, io, first fetch, halt, fetch status.
  always_comb begin
    strobes = 7'h7f;
    if (in_cycle) begin
      case (kind)
        BCS_MC_FETCH1: strobes = 7'h2a; // RQ1
        BCS_MC_FETCH2: strobes = 7'h2b; // RQ3
        BCS_MC_FETCH3: strobes = 7'h2b; // RQ5
        BCS_MC_MEMRD:  strobes = 7'h2f; // RQ9
        BCS_MC_MEMWR:  strobes = 7'h4f;
        BCS_MC_IORD:   strobes = 7'h37; // RQ7
        BCS_MC_ACK:    strobes = 7'h72; // RQ12
        BCS_MC_ACKX:   strobes = 7'h7e; // RQ16
        BCS_MC_SLEEP:  strobes = 7'h7d; // RQ6
        default:       strobes = 7'h7f;
      endcase
    end
  end
endmodule
